//--- hw/rmb_pkg.sv
// Purpose: constants and types of the radio MAC baseband interface
// Assumes: AHB-Lite register access, 100 MHz hclk
// Notes:
// Overview of operation
// (R1) tx data leaves lsb first, changed on tx bit clock rising edges
// (R2) baseband samples tx data on falling or rising edge by mode
// (R3) tx ready sampled on tx clock rising edge before a packet starts
// (R4) channel busy high blocks the switch from receive to transmit
// (R5) direction output shows read or write, changed on control clock fall
// (R6) address strobe high over address bits, low over data bits
// (R7) control clock is hclk divided by programmable ratio, default 14
// (R8) active-low select frames each control access
// (R9) shared serial control line carries address and data both ways
// (R10) software-driven output resets the baseband
// (R11) baseband tx power enable follows transmit mode
// (R12) tx mode output high in transmit, low in receive
// (R13) baseband rx power enable active while in receive mode
// (R14) pa power enable driven straight from a control bit
// (R15) three synthesizer latch enables pulsed high on command
// (R16) active-low radio power-down output from a control bit
// (R17) baseband frames receive data with frame valid
// (R18) rx inputs sampled on falling or rising rx clock edge by mode
// (R19) rx bits captured only while frame valid is high
// (R20) link quality output low for an error-free packet
// (R21) received bits assembled into bytes lsb first
// (R22) control access is address phase then data phase, select held low
package rmb_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLKDIV = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CTLCMD = 8'h14;
	localparam logic [7:0] OFS_CTLRD = 8'h18;
	localparam logic [7:0] OFS_SYNTH = 8'h1C;
	localparam int CMD_READ_BIT = 16;
	localparam int DIV_DEFAULT = 14;
	localparam int DIV_MIN = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNTH_PULSE_NS = 100;
	localparam int SYNTH_PULSE_CYC =
		(SYNTH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CTL_BITS = 8;
	typedef struct packed {
		logic pkt_error;
		logic rx_enable;
		logic tx_power_allow;
		logic rising_mode;
		logic radio_powerdown;
		logic bb_reset;
		logic pa_power;
		logic tx_request;
	} rmb_ctrl_t;
	localparam rmb_ctrl_t CTRL_RESET = 8'h3C;
	typedef struct packed {
		logic read;
		logic [7:0] data;
		logic [7:0] addr;
	} rmb_cmd_t;
	typedef enum logic [1:0] {
		CT_IDLE = 2'b00,
		CT_ADDR = 2'b01,
		CT_DATA = 2'b11,
		CT_END = 2'b10
	} rmb_ctl_state_t;
endpackage

//--- hw/rmb_radio_if.sv
// Purpose: MAC side of the radio baseband link with AHB-Lite registers
// Assumes: link inputs synchronous to hclk, bit clocks well below hclk/2
// Notes: zero wait-state slave, response always OKAY
`timescale 1ns/1ps
`default_nettype none
module rmb_radio_if #(
	parameter int DIV_W = 8,
	parameter int DIV_RESET = rmb_pkg::DIV_DEFAULT
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic tx_bit_clock,
	input wire logic tx_bb_ready,
	output logic tx_serial_out,
	input wire logic channel_busy,
	input wire logic rx_bit_clock,
	input wire logic rx_frame_valid,
	input wire logic rx_serial_in,
	output logic link_quality_n,
	output logic ctl_select_n,
	output logic ctl_serial_clk,
	output logic ctl_addr_strobe,
	output logic ctl_direction,
	input wire logic ctl_serial_in,
	output logic ctl_serial_out,
	output logic ctl_serial_oe_n,
	output logic bb_reset_n,
	output logic bb_tx_power_en,
	output logic bb_rx_power_en,
	output logic tx_mode_out,
	output logic pa_power_en,
	output logic synth_latch,
	output logic synth_latch_rf,
	output logic synth_latch_if,
	output logic radio_powerdown_n
);
	import rmb_pkg::*;

	if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div_w
		$error("DIV_W out of range");
	end
	if (DIV_RESET < DIV_MIN || DIV_RESET >= (1 << DIV_W)) begin : g_bad_rst
		$error("DIV_RESET does not fit");
	end

	function automatic logic rose(input logic cur, input logic prev);
		rose = cur & ~prev;
	endfunction

	// register bus
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic addr_phase;
	logic rd_take;
	logic wr_now;
	rmb_ctrl_t ctrl_r;
	logic [DIV_W-1:0] div_r;
	logic [7:0] tx_hold_r;
	logic tx_full_r;
	logic tx_busy_r;
	logic [7:0] rx_data_r;
	logic rx_valid_r;
	logic rx_overrun_r;
	logic rx_in_frame_r;
	logic [7:0] ctl_rd_r;
	rmb_cmd_t cmd_r;
	logic cmd_pend_r;
	rmb_ctl_state_t ctl_st_r;
	logic [2:0] synth_sel_r;
	logic [7:0] synth_cnt_r;
	logic tx_active_r;
	logic [31:0] rd_word;

	assign addr_phase = hsel & hready & htrans[1];
	assign rd_take = addr_phase & ~hwrite;
	assign wr_now = wr_pend_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (haddr[7:0])
			OFS_CTRL: rd_word[7:0] = ctrl_r;
			OFS_CLKDIV: rd_word[DIV_W-1:0] = div_r;
			OFS_TXDATA: rd_word[7:0] = tx_hold_r;
			OFS_RXDATA: rd_word[7:0] = rx_data_r;
			OFS_STATUS: rd_word[8:0] = {link_quality_n, channel_busy,
				tx_bb_ready, cmd_pend_r | (ctl_st_r != CT_IDLE),
				rx_in_frame_r, rx_overrun_r, rx_valid_r, tx_full_r,
				tx_busy_r};
			OFS_CTLCMD: rd_word[16:0] = cmd_r;
			OFS_CTLRD: rd_word[7:0] = ctl_rd_r;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= rd_word;
	end

	// (R10) (R14) (R16) control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_r <= CTRL_RESET;
		else if (wr_now && wr_addr_r == OFS_CTRL)
			ctrl_r <= hwdata[7:0];
	end

	// (R7) ratio kept at or above the minimum
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_r <= DIV_W'(DIV_RESET);
		else if (wr_now && wr_addr_r == OFS_CLKDIV) begin
			if (hwdata[DIV_W-1:0] < DIV_W'(DIV_MIN))
				div_r <= DIV_W'(DIV_MIN);
			else
				div_r <= hwdata[DIV_W-1:0];
		end
	end

	assign bb_reset_n = ~ctrl_r.bb_reset;
	assign pa_power_en = ctrl_r.pa_power;
	assign radio_powerdown_n = ~ctrl_r.radio_powerdown;
	// (R20) low while control bit pkt_error is clear
	assign link_quality_n = ctrl_r.pkt_error;

	// transmit / receive mode
	// (R4) switch to transmit only on a clear channel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_active_r <= 1'b0;
		else if (!ctrl_r.tx_request)
			tx_active_r <= 1'b0;
		else if (!channel_busy)
			tx_active_r <= 1'b1;
	end

	// (R12) tx mode level
	assign tx_mode_out = tx_active_r;
	// (R11) transmitter out of standby
	assign bb_tx_power_en = tx_active_r & ctrl_r.tx_power_allow;
	// (R13) receive mode enable
	assign bb_rx_power_en = ~tx_active_r & ctrl_r.rx_enable;

	// transmit shifter
	logic tx_clk_q_r;
	logic tx_rise;
	logic [7:0] tx_shift_r;
	logic [2:0] tx_cnt_r;
	logic tx_load;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_clk_q_r <= 1'b0;
		else
			tx_clk_q_r <= tx_bit_clock;
	end
	assign tx_rise = rose(tx_bit_clock, tx_clk_q_r);

	// (R3) ready checked at packet start
	assign tx_load = tx_rise & tx_full_r & (tx_busy_r ? (tx_cnt_r == 3'd7)
		: (tx_bb_ready & tx_active_r));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_hold_r <= 8'h00;
		else if (wr_now && wr_addr_r == OFS_TXDATA && !tx_full_r)
			tx_hold_r <= hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_full_r <= 1'b0;
		else if (wr_now && wr_addr_r == OFS_TXDATA && !tx_full_r)
			tx_full_r <= 1'b1;
		else if (tx_load)
			tx_full_r <= 1'b0;
	end

	// (R1) lsb first on rising tx clock edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_shift_r <= 8'h00;
			tx_cnt_r <= 3'd0;
			tx_busy_r <= 1'b0;
			tx_serial_out <= 1'b0;
		end else if (tx_load) begin
			tx_shift_r <= {1'b0, tx_hold_r[7:1]};
			tx_serial_out <= tx_hold_r[0];
			tx_cnt_r <= 3'd0;
			tx_busy_r <= 1'b1;
		end else if (tx_rise && tx_busy_r) begin
			if (tx_cnt_r == 3'd7) begin
				tx_busy_r <= 1'b0;
				tx_serial_out <= 1'b0;
			end else begin
				tx_serial_out <= tx_shift_r[0];
				tx_shift_r <= {1'b0, tx_shift_r[7:1]};
				tx_cnt_r <= tx_cnt_r + 3'd1;
			end
		end
	end

	// receive shifter
	logic rx_clk_q_r;
	logic rx_sample;
	logic [7:0] rx_shift_r;
	logic [2:0] rx_cnt_r;
	logic rx_byte_done;
	logic rx_read;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_clk_q_r <= 1'b0;
		else
			rx_clk_q_r <= rx_bit_clock;
	end

	// (R18) sample edge chosen by mode
	assign rx_sample = ctrl_r.rising_mode ? rose(rx_bit_clock, rx_clk_q_r)
		: rose(rx_clk_q_r, rx_bit_clock);
	assign rx_byte_done = rx_sample & rx_frame_valid & (rx_cnt_r == 3'd7);
	assign rx_read = rd_take & (haddr[7:0] == OFS_RXDATA);

	// (R19) (R21) capture in frame, lsb first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_shift_r <= 8'h00;
			rx_cnt_r <= 3'd0;
			rx_in_frame_r <= 1'b0;
		end else if (rx_sample) begin
			rx_in_frame_r <= rx_frame_valid;
			if (rx_frame_valid) begin
				rx_shift_r <= {rx_serial_in, rx_shift_r[7:1]};
				rx_cnt_r <= rx_cnt_r + 3'd1;
			end else begin
				rx_cnt_r <= 3'd0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_data_r <= 8'h00;
		else if (rx_byte_done)
			rx_data_r <= {rx_serial_in, rx_shift_r[7:1]};
	end

	// new byte wins over a read in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_valid_r <= 1'b0;
		else if (rx_byte_done)
			rx_valid_r <= 1'b1;
		else if (rx_read)
			rx_valid_r <= 1'b0;
	end

	// overrun cleared by a status write of bit 2
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_overrun_r <= 1'b0;
		else if (rx_byte_done && rx_valid_r && !rx_read)
			rx_overrun_r <= 1'b1;
		else if (wr_now && wr_addr_r == OFS_STATUS && hwdata[2])
			rx_overrun_r <= 1'b0;
	end

	// control serial port
	logic [DIV_W-1:0] div_cnt_r;
	logic sclk_fall;
	logic sclk_rise;
	logic [2:0] ctl_cnt_r;
	logic [7:0] ctl_shift_r;

	// (R7) divided control clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt_r <= '0;
		else if (div_cnt_r >= div_r - DIV_W'(1))
			div_cnt_r <= '0;
		else
			div_cnt_r <= div_cnt_r + DIV_W'(1);
	end
	assign sclk_rise = (div_cnt_r == '0);
	assign sclk_fall = (div_cnt_r == (div_r >> 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctl_serial_clk <= 1'b0;
		else if (sclk_rise)
			ctl_serial_clk <= 1'b1;
		else if (sclk_fall)
			ctl_serial_clk <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cmd_r <= '0;
		else if (wr_now && wr_addr_r == OFS_CTLCMD && !cmd_pend_r
			&& ctl_st_r == CT_IDLE)
			cmd_r <= hwdata[CMD_READ_BIT:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cmd_pend_r <= 1'b0;
		else if (wr_now && wr_addr_r == OFS_CTLCMD && !cmd_pend_r
			&& ctl_st_r == CT_IDLE)
			cmd_pend_r <= 1'b1;
		else if (sclk_fall && ctl_st_r == CT_IDLE)
			cmd_pend_r <= 1'b0;
	end

	// (R22) address phase then data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_st_r <= CT_IDLE;
			ctl_cnt_r <= 3'd0;
			ctl_shift_r <= 8'h00;
			ctl_select_n <= 1'b1;
			ctl_addr_strobe <= 1'b0;
			ctl_direction <= 1'b0;
			ctl_serial_out <= 1'b0;
			ctl_serial_oe_n <= 1'b1;
		end else if (sclk_fall) begin
			unique case (ctl_st_r)
				CT_IDLE: begin
					if (cmd_pend_r) begin
						// (R8) select held over the access
						ctl_select_n <= 1'b0;
						// (R5) direction set on a fall
						ctl_direction <= cmd_r.read;
						// (R6) strobe high over address
						ctl_addr_strobe <= 1'b1;
						// (R9) drive address lsb first
						ctl_serial_out <= cmd_r.addr[0];
						ctl_serial_oe_n <= 1'b0;
						ctl_shift_r <= {1'b0, cmd_r.addr[7:1]};
						ctl_cnt_r <= 3'd0;
						ctl_st_r <= CT_ADDR;
					end
				end
				CT_ADDR: begin
					if (ctl_cnt_r == 3'(CTL_BITS - 1)) begin
						// (R6) strobe low over data
						ctl_addr_strobe <= 1'b0;
						ctl_cnt_r <= 3'd0;
						ctl_st_r <= CT_DATA;
						ctl_serial_out <= cmd_r.read ? 1'b0 : cmd_r.data[0];
						ctl_serial_oe_n <= cmd_r.read;
						ctl_shift_r <= {1'b0, cmd_r.data[7:1]};
					end else begin
						ctl_serial_out <= ctl_shift_r[0];
						ctl_shift_r <= {1'b0, ctl_shift_r[7:1]};
						ctl_cnt_r <= ctl_cnt_r + 3'd1;
					end
				end
				CT_DATA: begin
					if (ctl_cnt_r == 3'(CTL_BITS - 1)) begin
						ctl_select_n <= 1'b1;
						ctl_serial_oe_n <= 1'b1;
						ctl_serial_out <= 1'b0;
						ctl_direction <= 1'b0;
						ctl_st_r <= CT_END;
					end else begin
						if (!cmd_r.read)
							ctl_serial_out <= ctl_shift_r[0];
						ctl_shift_r <= {1'b0, ctl_shift_r[7:1]};
						ctl_cnt_r <= ctl_cnt_r + 3'd1;
					end
				end
				CT_END: ctl_st_r <= CT_IDLE;
			endcase
		end
	end

	// (R9) read data taken on rising control clock edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctl_rd_r <= 8'h00;
		else if (sclk_rise && ctl_st_r == CT_DATA && cmd_r.read)
			ctl_rd_r <= {ctl_serial_in, ctl_rd_r[7:1]};
	end

	// synthesizer latches
	// (R15) latch pulse of fixed width
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			synth_sel_r <= 3'b000;
			synth_cnt_r <= 8'h00;
		end else if (wr_now && wr_addr_r == OFS_SYNTH && synth_cnt_r == 8'h00
			&& hwdata[2:0] != 3'b000) begin
			synth_sel_r <= hwdata[2:0];
			synth_cnt_r <= 8'(SYNTH_PULSE_CYC);
		end else if (synth_cnt_r != 8'h00) begin
			synth_cnt_r <= synth_cnt_r - 8'h01;
			if (synth_cnt_r == 8'h01)
				synth_sel_r <= 3'b000;
		end
	end

	assign synth_latch = synth_sel_r[0];
	assign synth_latch_rf = synth_sel_r[1];
	assign synth_latch_if = synth_sel_r[2];

endmodule
`default_nettype wire

//--- testbench/rmb_radio_if_assertions.sv
// Purpose: port checks of the radio link block
// Assumes: one hclk domain, divider left at reset value
// Notes: bound to the design below
`timescale 1ns/1ps
`default_nettype none
module rmb_radio_if_chk #(
	parameter int DIV_RESET = 14
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic tx_bit_clock,
	input wire logic tx_serial_out,
	input wire logic channel_busy,
	input wire logic ctl_select_n,
	input wire logic ctl_serial_clk,
	input wire logic ctl_addr_strobe,
	input wire logic ctl_direction,
	input wire logic ctl_serial_oe_n,
	input wire logic bb_tx_power_en,
	input wire logic bb_rx_power_en,
	input wire logic tx_mode_out,
	input wire logic synth_latch
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	AST_PWR_MODE: assert property (
		!(bb_tx_power_en && !tx_mode_out) && !(bb_rx_power_en && tx_mode_out))
		else $error("power enable against mode");
	AST_SEL_EDGE: assert property (
		$changed(ctl_select_n) |-> $fell(ctl_serial_clk))
		else $error("select moved off a falling edge");
	AST_STROBE_EDGE: assert property (
		$changed(ctl_addr_strobe) |-> $fell(ctl_serial_clk))
		else $error("strobe moved off a falling edge");
	AST_DIR_EDGE: assert property (
		$changed(ctl_direction) |-> $fell(ctl_serial_clk))
		else $error("direction moved off a falling edge");
	AST_STROBE_SEL: assert property (
		ctl_addr_strobe |-> !ctl_select_n)
		else $error("strobe without select");
	AST_LINE_OWNER: assert property (
		!ctl_serial_oe_n |-> !ctl_select_n &&
		(ctl_addr_strobe || !ctl_direction))
		else $error("line driven in a read data phase");
	AST_CTL_PERIOD: assert property (
		$rose(ctl_serial_clk) |-> ##DIV_RESET $rose(ctl_serial_clk))
		else $error("control clock period wrong");
	AST_TXD_EDGE: assert property (
		$changed(tx_serial_out) |-> tx_bit_clock && !$past(tx_bit_clock, 3))
		else $error("tx data moved off a rising bit clock");
	AST_BUSY_HOLD: assert property (
		channel_busy && $past(channel_busy) && $past(channel_busy, 2)
		|-> !$rose(tx_mode_out))
		else $error("transmit began on a busy channel");
	AST_SYNTH_WIDTH: assert property (
		$rose(synth_latch) |-> synth_latch[*8] ##1 synth_latch
		##1 synth_latch ##1 !synth_latch)
		else $error("latch pulse not ten cycles");
	cover property ($rose(tx_mode_out));
	cover property ($fell(ctl_addr_strobe) && ctl_direction);
	cover property ($fell(ctl_addr_strobe) && !ctl_direction);
endmodule
bind rmb_radio_if rmb_radio_if_chk #(.DIV_RESET(DIV_RESET)) chk_i (.*);
`default_nettype wire

//--- testbench/rmb_bb_model.sv
// Purpose: behavioural baseband beside the radio link block
// Assumes: bit clocks of 80 ns, control line without pull
// Notes: rx clock runs one cycle past each frame, then rests low
`timescale 1ns/1ps
`default_nettype none
module rmb_bb_model (
	input wire logic hclk,
	input wire logic want_ready,
	input wire logic bb_tx_power_en,
	output logic tx_bit_clock,
	output logic tx_bb_ready,
	input wire logic tx_serial_out,
	output logic rx_bit_clock,
	output logic rx_frame_valid,
	output logic rx_serial_in,
	input wire logic ctl_select_n,
	input wire logic ctl_serial_clk,
	input wire logic ctl_addr_strobe,
	input wire logic ctl_direction,
	input wire logic ctl_serial_out,
	input wire logic ctl_serial_oe_n,
	output logic ctl_serial_in
);
	logic [7:0] mem [256];
	logic [7:0] addr, dat;
	logic [2:0] k;
	logic armed, tog, drv;
	logic q [$];
	initial begin
		{tx_bit_clock, tx_bb_ready, armed, tog, k} = '0;
		{rx_bit_clock, rx_frame_valid, rx_serial_in} = '0;
		forever #40 tx_bit_clock = bb_tx_power_en & ~tx_bit_clock;
	end
	always @(negedge tx_bit_clock) if (armed) q.push_back(tx_serial_out);
	// ready offered, seen at a rise
	always @(negedge tx_bit_clock) tx_bb_ready <= want_ready;
	always @(posedge tx_bit_clock) armed <= armed | tx_bb_ready;
	always @(posedge hclk) tog <= ~tog;
	// answer only in read data phase
	always_comb begin
		drv = tog;
		if (!ctl_select_n && ctl_direction && !ctl_addr_strobe)
			drv = mem[addr][k];
	end
	assign ctl_serial_in = ctl_serial_oe_n ? drv : ctl_serial_out;
	always @(posedge ctl_serial_clk) if (!ctl_select_n) begin
		if (ctl_addr_strobe) begin
			addr <= {ctl_serial_in, addr[7:1]};
			k <= 3'h0;
		end else begin
			dat <= {ctl_serial_in, dat[7:1]};
			k <= k + 3'h1;
			if (k == 3'h7 && !ctl_direction)
				mem[addr] <= {ctl_serial_in, dat[7:1]};
		end
	end
	task automatic rx_frame(input logic [7:0] d, input int n,
		input logic rise);
		// keep link edges clear of hclk edges
		#2;
		for (int i = 0; i < n; i++) begin
			rx_frame_valid = 1'h1;
			rx_serial_in = ~d[i];
			rx_bit_clock = ~rise;
			#30 rx_serial_in = d[i];
			#10 rx_bit_clock = rise;
			#40;
		end
		rx_frame_valid = 1'h0;
		rx_bit_clock = ~rise;
		#40 rx_bit_clock = rise;
		#40 rx_bit_clock = 1'h0;
		rx_serial_in = ~rx_serial_in;
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_radio_mac_baseband_interface.sv
// Purpose: self-checking bench of the radio link block
// Assumes: divider left at 14, bit clocks from the model
// Notes: seed 79 makes the run repeatable
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_radio_mac_baseband_interface;
	import rmb_pkg::*;
	logic hclk, hresetn, hsel, hwrite, want_ready, channel_busy;
	logic [31:0] haddr, hwdata, rd, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, s;
	logic [7:0] v, a, b0, b1;
	logic [15:0] tw;
	logic hreadyout, hresp, tx_bit_clock, tx_bb_ready, tx_serial_out;
	logic rx_bit_clock, rx_frame_valid, rx_serial_in, link_quality_n;
	logic ctl_select_n, ctl_serial_clk, ctl_addr_strobe, ctl_direction;
	logic ctl_serial_in, ctl_serial_out, ctl_serial_oe_n, bb_reset_n;
	logic bb_tx_power_en, bb_rx_power_en, tx_mode_out, pa_power_en;
	logic synth_latch, synth_latch_rf, synth_latch_if, radio_powerdown_n;
	int n_errors = 0, total_checks = 0, seed = 79, hi, tot;
	rmb_radio_if rmb_radio_if_i (.hready(hreadyout), .*);
	rmb_bb_model rmb_bb_model_i (.*);
	function automatic logic [5:0] pins(input logic [7:0] c);
		return {c[7], ~c[3], ~c[2], c[1], 2'h2};
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic hrdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'h1 && i < 20);
		if (hreadyout !== 1'h1) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		hrdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		hrdy;
		rd = hrdata;
	endtask
	task automatic poll(input int b);
		int i;
		for (i = 0; i < 400; i++) begin
			bus(1'h0, OFS_STATUS, 32'h0);
			if (rd[b] === 1'h0) break;
		end
		if (i == 400) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, want_ready, channel_busy} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		`CHK({bb_reset_n, radio_powerdown_n, pa_power_en}, 3'h0)
		bus(1'h0, OFS_CLKDIV, 32'h0);
		`CHK(rd, 32'hE)
		bus(1'h1, 8'h40, 32'hFFFFFFFF);
		bus(1'h0, 8'h40, 32'h0);
		`CHK(rd, 32'h0)
		repeat (4) begin
			v = 8'h40 | (8'h8E & 8'($random(seed)));
			bus(1'h1, OFS_CTRL, {24'h0, v});
			@(posedge hclk);
			`CHK({link_quality_n, radio_powerdown_n, bb_reset_n, pa_power_en, bb_rx_power_en, tx_mode_out}, pins(v))
		end
		for (int i = 0; i < 3; i++) begin
			bus(1'h1, OFS_SYNTH, 32'h1 << i);
			{hi, tot} = '0;
			repeat (20) begin
				@(posedge hclk);
				s = {synth_latch_if, synth_latch_rf, synth_latch};
				hi += int'(s[i]);
				tot += $countones(s);
			end
			`CHK(hi, 10)
			`CHK(tot, 10)
		end
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		channel_busy <= 1'h1;
		bus(1'h1, OFS_TXDATA, {24'h0, b0});
		bus(1'h1, OFS_CTRL, 32'h61);
		repeat (40) @(posedge hclk);
		`CHK(tx_mode_out, 1'h0)
		channel_busy <= 1'h0;
		bus(1'h1, OFS_CTRL, 32'h60);
		bus(1'h1, OFS_CTRL, 32'h61);
		repeat (40) @(posedge hclk);
		`CHK({tx_mode_out, bb_tx_power_en}, 2'h3)
		bus(1'h0, OFS_STATUS, 32'h0);
		`CHK(rd[1:0], 2'h2)
		want_ready <= 1'h1;
		poll(1);
		bus(1'h1, OFS_TXDATA, {24'h0, b1});
		poll(0);
		tw = {b1, b0};
		for (int i = 0; i < 16; i++)
			`CHK(rmb_bb_model_i.q[i], tw[i])
		bus(1'h1, OFS_CTRL, 32'h40);
		repeat (2) begin
			v = 8'($random(seed));
			a = 8'($random(seed));
			bus(1'h1, OFS_CTLCMD, {16'h0, v, a});
			repeat (16) @(posedge hclk);
			poll(5);
			`CHK(rmb_bb_model_i.mem[a], v)
			bus(1'h1, OFS_CTLCMD, {15'h0, 1'h1, 8'h0, a});
			repeat (16) @(posedge hclk);
			poll(5);
			bus(1'h0, OFS_CTLRD, 32'h0);
			`CHK(rd, {24'h0, v})
		end
		for (int m = 0; m < 2; m++) begin
			v = 8'($random(seed));
			bus(1'h1, OFS_CTRL, {25'h0, 1'h1, 1'h0, m[0], 4'h0});
			rmb_bb_model_i.rx_frame(~v, 3, m[0]);
			rmb_bb_model_i.rx_frame(v, 8, m[0]);
			@(posedge hclk);
			bus(1'h0, OFS_STATUS, 32'h0);
			`CHK(rd[3:2], 2'h1)
			bus(1'h0, OFS_RXDATA, 32'h0);
			`CHK(rd, {24'h0, v})
		end
		rmb_bb_model_i.rx_frame(v, 8, 1'h1);
		rmb_bb_model_i.rx_frame(~v, 8, 1'h1);
		@(posedge hclk);
		bus(1'h0, OFS_STATUS, 32'h0);
		`CHK(rd[3:2], 2'h3)
		bus(1'h1, OFS_STATUS, 32'h4);
		bus(1'h0, OFS_RXDATA, 32'h0);
		`CHK(rd, {24'h0, ~v})
		bus(1'h0, OFS_STATUS, 32'h0);
		`CHK(rd[3:2], 2'h0)
		tally_and_finish;
	end
endmodule
`default_nettype wire
